// >>> rtl/flash_page_pkg.sv
// package with address windows, page codes and variant encodings
package flash_page_pkg;
   localparam logic [5:0] PAGE_BOTTOM   = 6'h3D;
   localparam logic [5:0] PAGE_MIDDLE   = 6'h3E;
   localparam logic [5:0] PAGE_TOP      = 6'h3F;
   localparam logic [5:0] PAGE_128K_LO  = 6'h38;
   localparam logic [2:0] LOW_64K_MIN   = 3'h4;
   localparam logic [2:0] LOW_96K_MIN   = 3'h2;
   localparam logic [1:0] WIN_BOTTOM    = 2'h0;
   localparam logic [1:0] WIN_MIDDLE    = 2'h1;
   localparam logic [1:0] WIN_PAGED     = 2'h2;
   localparam logic [1:0] WIN_TOP       = 2'h3;
   localparam logic [1:0] RESET_VARIANT = 2'h3;
   localparam int         ADDR_WIN_MSB  = 15;
   localparam int         ADDR_WIN_LSB  = 14;
   localparam int         ADDR_OFS_MSB  = 13;
   localparam int         PAGE_SLOTS    = 8;

   typedef enum logic [1:0] {
      VAR_32K,
      VAR_64K,
      VAR_96K,
      VAR_128K
   } flash_variant_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
   } cpu_req_t;

   typedef struct packed {
      logic        flash_sel;
      logic        pass_on;
      logic [5:0]  page;
      logic [13:0] offset;
   } flash_map_t;
endpackage

// >>> rtl/paged_window_map.sv
// maps a page select value to the physical page of the paged window
`timescale 1ns/10ps
`default_nettype none
module paged_window_map
   import flash_page_pkg::*;
(
   input  wire logic [7:0]     program_page_select,
   input  wire flash_variant_t variant,
   output logic                hit,
   output logic [5:0]          page
);
   logic [2:0] low;

   always_comb begin
      low  = program_page_select[2:0];
      hit  = 1'b0;
      page = PAGE_TOP;
      case (variant)
         VAR_32K: begin
            hit  = 1'b1;
            page = program_page_select[0] ? PAGE_TOP : PAGE_MIDDLE;
         end
         VAR_64K: begin
            hit  = (low >= LOW_64K_MIN);
            page = PAGE_128K_LO | {3'h0, low};
         end
         VAR_96K: begin
            hit  = (low >= LOW_96K_MIN);
            page = PAGE_128K_LO | {3'h0, low};
         end
         default: begin
            hit  = 1'b1;
            page = PAGE_128K_LO | {3'h0, low};
         end
      endcase
   end
endmodule
`default_nettype wire

// >>> rtl/flash_page_window_decoder.sv
// flash page window decoder: cpu address to internal flash page
//
// Contract
// - no external page bits; every paged hit resolves to an internal page
// - window 8000-BFFF shows the page chosen by page select
// - with flash enabled, C000-FFFF always maps to page 3F
// - with flash enabled and middle not hidden, 4000-7FFF maps to 3E
// - with flash enabled, 0000-3FFF maps to page 3D except 32K
// - 128K: paged window shows 38-3F from low three select bits
// - 64K low bits 4-7 give 3C-3F; 96K low bits 2-7 give 3A-3F
// - 32K: even select shows 3E, odd shows 3F
`timescale 1ns/10ps
`default_nettype none
module flash_page_window_decoder
   import flash_page_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst,
   input  wire cpu_req_t       req,
   input  wire logic [7:0]     program_page_select,
   input  wire logic           flash_enable,
   input  wire logic           flash_hide_middle,
   input  wire flash_variant_t variant,
   output flash_map_t          map
);
   typedef struct packed {
      flash_map_t map_r;
   } state_t;

   state_t     st_r;
   state_t     st_nxt;
   logic       paged_hit;
   logic [5:0] paged_page;
   logic [1:0] win;

   // one decode of the window bits, shared by the map logic and the checkers from a_hide_top_kept on
   function automatic logic [1:0] window_of(input logic [15:0] addr);
      return addr[ADDR_WIN_MSB:ADDR_WIN_LSB];
   endfunction

   // the paged lookup is shared with nothing else, kept apart for clarity
   paged_window_map u_map (
      .program_page_select (program_page_select),
      .variant             (variant),
      .hit                 (paged_hit),
      .page                (paged_page)
   );

   always_comb begin
      st_nxt = '0;
      win    = window_of(req.addr);
      st_nxt.map_r.offset = req.addr[ADDR_OFS_MSB:0];
      if (req.valid && flash_enable) begin
         if (win == WIN_TOP) begin
            st_nxt.map_r.flash_sel = 1'b1;
            st_nxt.map_r.page      = PAGE_TOP;
         end else if (win == WIN_PAGED) begin
            st_nxt.map_r.flash_sel = paged_hit;
            st_nxt.map_r.page      = paged_page;
         end else if (win == WIN_MIDDLE) begin
            // no 16K variant is supported, so the exception never applies
            st_nxt.map_r.flash_sel = !flash_hide_middle;
            st_nxt.map_r.page      = PAGE_MIDDLE;
         end else begin
            st_nxt.map_r.flash_sel = (variant != VAR_32K);
            st_nxt.map_r.page      = PAGE_BOTTOM;
         end
      end
      st_nxt.map_r.pass_on = req.valid && !st_nxt.map_r.flash_sel;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign map = st_r.map_r;

   a_top_fixed: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && req.addr[15:14] == WIN_TOP)
      |=> (map.flash_sel && map.page == PAGE_TOP))
      else $error("top window not mapped to page 3F");
   a_middle_fixed: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && !flash_hide_middle
       && req.addr[15:14] == WIN_MIDDLE)
      |=> (map.flash_sel && map.page == PAGE_MIDDLE))
      else $error("middle window not mapped to page 3E");
   a_middle_hidden: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_hide_middle && req.addr[15:14] == WIN_MIDDLE)
      |=> (!map.flash_sel && map.pass_on))
      else $error("hidden middle window selected flash");
   a_bottom_fixed: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && req.addr[15:14] == WIN_BOTTOM)
      |=> (map.flash_sel == ($past(variant) != VAR_32K)
           && (!map.flash_sel || map.page == PAGE_BOTTOM)))
      else $error("bottom window mapping wrong");
   a_paged_128k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_128K
       && req.addr[15:14] == WIN_PAGED)
      |=> (map.flash_sel
           && map.page[2:0] == $past(program_page_select[2:0])
           && map.page[5:3] == PAGE_128K_LO[5:3]))
      else $error("128K paged mapping wrong");
   a_paged_partial: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_64K
       && req.addr[15:14] == WIN_PAGED)
      |=> (map.flash_sel == ($past(program_page_select[2:0]) >= LOW_64K_MIN)))
      else $error("64K paged hit wrong");
   a_paged_32k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_32K
       && req.addr[15:14] == WIN_PAGED)
      |=> (map.page == ($past(program_page_select[0]) ? PAGE_TOP
                                                       : PAGE_MIDDLE)))
      else $error("32K paged mapping wrong");
   a_disabled_pass: assert property (@(posedge clk) disable iff (rst)
      (req.valid && !flash_enable) |=> (!map.flash_sel && map.pass_on))
      else $error("flash selected while disabled");
   a_offset_kept: assert property (@(posedge clk) disable iff (rst)
      req.valid |=> (map.offset == $past(req.addr[13:0])))
      else $error("offset not carried");

   // fixed windows under the hide and variant controls
   a_hide_top_kept: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && flash_hide_middle
       && window_of(req.addr) == WIN_TOP)
      |=> (map.flash_sel && map.page == PAGE_TOP))
      else $error("hide control disturbed the top window");

   a_top_32k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_32K
       && window_of(req.addr) == WIN_TOP)
      |=> (map.flash_sel && map.page == PAGE_TOP))
      else $error("32K top window not mapped to page 3F");

   a_middle_32k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && !flash_hide_middle && variant == VAR_32K
       && window_of(req.addr) == WIN_MIDDLE)
      |=> (map.flash_sel && map.page == PAGE_MIDDLE))
      else $error("32K middle window not mapped to page 3E");

   a_bottom_32k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_32K
       && window_of(req.addr) == WIN_BOTTOM)
      |=> (!map.flash_sel && map.pass_on))
      else $error("32K bottom window selected flash");

   a_hide_bottom: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && flash_hide_middle && variant != VAR_32K
       && window_of(req.addr) == WIN_BOTTOM)
      |=> (map.flash_sel && map.page == PAGE_BOTTOM))
      else $error("hide control disturbed the bottom window");

   // paged window per variant
   a_hide_paged: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && flash_hide_middle && variant == VAR_128K
       && window_of(req.addr) == WIN_PAGED)
      |=> map.flash_sel)
      else $error("hide control disturbed the paged window");

   a_paged_96k: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_96K
       && window_of(req.addr) == WIN_PAGED)
      |=> (map.flash_sel == ($past(program_page_select[2:0]) >= LOW_96K_MIN)))
      else $error("96K paged hit wrong");

   a_paged_32k_sel: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_32K
       && window_of(req.addr) == WIN_PAGED)
      |=> (map.flash_sel && !map.pass_on))
      else $error("32K paged window not selected");

   a_paged_refused: assert property (@(posedge clk) disable iff (rst)
      (req.valid && flash_enable && variant == VAR_64K
       && window_of(req.addr) == WIN_PAGED
       && program_page_select[2:0] < LOW_64K_MIN)
      |=> (!map.flash_sel && map.pass_on))
      else $error("unimplemented page selected flash");

   // one checker per select slot: a stuck page bit shows up by slot, and
   // the upper select bits must not disturb the slot they land in
   for (genvar k = 0; k < PAGE_SLOTS; k++) begin : g_slot
      a_slot_page: assert property (@(posedge clk) disable iff (rst)
         (req.valid && flash_enable && variant != VAR_32K
          && window_of(req.addr) == WIN_PAGED
          && program_page_select[2:0] == 3'(k))
         |=> (!map.flash_sel || map.page == (PAGE_128K_LO | 6'(k))))
         else $error("paged slot mapped to wrong page");
   end

   // every access resolves exactly one way, and only when asked
   a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
      !req.valid |=> (!map.flash_sel && !map.pass_on))
      else $error("idle cycle produced a map result");

   a_one_outcome: assert property (@(posedge clk) disable iff (rst)
      req.valid |=> (map.flash_sel != map.pass_on))
      else $error("valid access not resolved exactly once");

   a_sel_needs_on: assert property (@(posedge clk) disable iff (rst)
      map.flash_sel |-> $past(flash_enable && req.valid))
      else $error("flash selected without an enabled access");

   a_pass_on_req: assert property (@(posedge clk) disable iff (rst)
      map.pass_on |-> $past(req.valid))
      else $error("pass on raised without an access");

   a_page_internal: assert property (@(posedge clk) disable iff (rst)
      map.flash_sel |-> (map.page[5:3] == PAGE_128K_LO[5:3]))
      else $error("selected page outside internal flash");

   c_paged: cover property (@(posedge clk) disable iff (rst)
      map.flash_sel && $past(req.addr[15:14]) == WIN_PAGED);
   c_top: cover property (@(posedge clk) disable iff (rst)
      map.flash_sel && map.page == PAGE_TOP);
   c_pass: cover property (@(posedge clk) disable iff (rst) map.pass_on);
   c_middle: cover property (@(posedge clk) disable iff (rst)
      map.flash_sel && map.page == PAGE_MIDDLE);
   c_refused: cover property (@(posedge clk) disable iff (rst)
      map.pass_on && $past(flash_enable && req.valid));
endmodule
`default_nettype wire

// >>> tb/cpu_model.sv
// processor core model issuing one address per cycle
`timescale 1ns/10ps
`default_nettype none
module cpu_model
   import flash_page_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        go,
   input  wire logic [15:0] addr,
   output cpu_req_t         req
);
   // idle address is inverted so a stale address never looks live
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req <= '{valid: 1'b0, addr: 16'hFFFF};
      end else begin
         req <= '{valid: go, addr: go ? addr : ~req.addr};
      end
   end
endmodule
`default_nettype wire

// >>> tb/test_flash_page_window_decoder.sv
// testbench for the flash page window decoder
`timescale 1ns/10ps
`default_nettype none
module test_flash_page_window_decoder;
   import flash_page_pkg::*;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           go = 1'b0;
   logic           en = 1'b0;
   logic           hide = 1'b0;
   logic [15:0]    a = 16'h0000;
   logic [7:0]     ps = 8'h00;
   flash_variant_t v = VAR_128K;
   cpu_req_t       req;
   flash_map_t     map;
   int             fails = 0;
   int             checks_done = 0;
   cpu_model cpu_model_i (.clk(clk), .rst(rst), .go(go), .addr(a), .req(req));
   flash_page_window_decoder flash_page_window_decoder_i (.clk(clk),
      .rst(rst), .req(req), .program_page_select(ps), .flash_enable(en),
      .flash_hide_middle(hide), .variant(v), .map(map));
   initial forever #20 clk = ~clk;
   task check(logic [21:0] seen, logic [21:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t map %h expected %h", $time, seen, exp);
      end
   endtask
   // page is only meaningful while flash is selected, so it is masked
   task judge();
      logic s;
      logic [5:0] pg;
      s = 1'b0;
      pg = {3'h7, ps[2:0]};
      if (en) begin
         case (a[15:14])
            2'h3: s = 1'b1;
            2'h1: s = !hide;
            2'h0: s = (v != VAR_32K);
            default: s = v == VAR_128K || (v == VAR_96K && ps[2:0] >= 3'h2)
                  || (v == VAR_64K && ps[2:0] >= 3'h4);
         endcase
         if (a[15:14] == 2'h3) pg = 6'h3F;
         if (a[15:14] == 2'h1) pg = 6'h3E;
         if (a[15:14] == 2'h0) pg = 6'h3D;
         if (a[15:14] == 2'h2 && v == VAR_32K) begin
            s = 1'b1;
            pg = {5'h1F, ps[0]};
         end
      end
      check({map.flash_sel, map.pass_on, s ? map.page : 6'h00, map.offset},
            {s, !s, s ? pg : 6'h00, a[13:0]});
   endtask
   task access(logic [15:0] ad, logic [7:0] p, logic e, logic h, int vi);
      @(posedge clk);
      go <= 1'b1;
      a <= ad;
      ps <= p;
      en <= e;
      hide <= h;
      v <= flash_variant_t'(vi[1:0]);
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   task t_paged();
      for (int i = 0; i < 4; i++) begin
         for (int p = 0; p < 16; p++) begin
            access(16'h8000 + 16'(p) * 16'h0401, 8'(p) * 8'h11, 1'b1, 1'b0, i);
            judge();
         end
      end
      $display("paged window test done");
   endtask
   task t_fixed();
      for (int i = 0; i < 4; i++) begin
         for (int w = 0; w < 16; w++) begin
            access({w[1:0], 14'h1234}, 8'h05, !w[3], w[2], i);
            judge();
         end
      end
      $display("fixed window test done");
   endtask
   // reset lands while a request keeps the map busy, so a clear shows
   task t_reset();
      @(posedge clk);
      go <= 1'b1;
      a <= 16'hC000;
      en <= 1'b1;
      hide <= 1'b0;
      v <= VAR_128K;
      repeat (2) @(posedge clk);
      #1;
      judge();
      @(posedge clk);
      rst <= 1'b1;
      #1;
      check(map, 22'h000000);
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      judge();
      $display("reset test done");
   endtask
   task t_idle();
      @(posedge clk);
      #1;
      check({20'h00000, map.flash_sel, map.pass_on}, 22'h000000);
      $display("idle test done");
   endtask
   task wrap_up();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check(map, 22'h000000);
      t_paged();
      t_fixed();
      t_reset();
      t_idle();
      wrap_up();
   end
endmodule
`default_nettype wire
